// ===== hdl/charge_ctrl_pkg.sv
// Package: constants, modes, states and carriers for the charge mode control.
// Assumes one 20 MHz system clock and an active-low power-on reset.
package charge_ctrl_pkg;

	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_HZ = 20_000_000;
	localparam int unsigned READY_HOLD_MS = 500;
	localparam int unsigned READY_HOLD_CYCLES = (CLK_HZ / 1000) * READY_HOLD_MS;
	localparam int unsigned RAMP_STEP_CYCLES = 16;

	// ==========================================================
	// Register field positions
	localparam int unsigned CTRL1_TE_BIT = 3;
	localparam int unsigned CTRL1_INPUT_CURRENT_LIMIT_LSB = 6;
	localparam int unsigned CTRL1_WEAK_LSB = 4;
	localparam int unsigned CTRL1_HZ_BIT = 1;
	localparam int unsigned CTRL1_CD_BIT = 2;
	localparam int unsigned REG2_FLOAT_LSB = 2;
	localparam int unsigned REG4_ICHG_LSB = 4;
	localparam int unsigned REG4_TERMINATION_CURRENT_CODE_LSB = 0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] CTRL1_RESET = 8'h30;
	localparam logic [7:0] REG2_RESET = 8'h0a;
	localparam logic [7:0] REG4_RESET = 8'h00;

	// ==========================================================
	// Float voltage: 3.5 V plus 20 mV per code, saturating at 4.44 V
	localparam int unsigned FLOAT_BASE_MV = 3500;
	localparam int unsigned FLOAT_STEP_MV = 20;
	localparam logic [5:0] FLOAT_MAX_CODE = 6'h2f;

	// Input current limit in mA; no-limit reads as all ones
	localparam logic [11:0] INPUT_CURRENT_LIMIT_100_MA = 12'h064;
	localparam logic [11:0] INPUT_CURRENT_LIMIT_500_MA = 12'h1f4;
	localparam logic [11:0] INPUT_CURRENT_LIMIT_800_MA = 12'h320;
	localparam logic [11:0] INPUT_CURRENT_LIMIT_NONE_MA = 12'hfff;

	// Status codes
	localparam logic [1:0] STAT_READY = 2'h0;
	localparam logic [1:0] STAT_CHARGING = 2'h1;
	localparam logic [1:0] STAT_DONE = 2'h2;

	typedef enum logic [1:0] {
		MODE_HIZ = 2'h0,
		MODE_CHARGE = 2'h1,
		MODE_BOOST = 2'h2
	} op_mode_t;

	// Gray codes along idle, pre, cc, cv, term check, done
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_PRE = 3'h1,
		ST_CC = 3'h3,
		ST_CV = 3'h2,
		ST_TERM = 3'h6,
		ST_DONE = 3'h7
	} chg_state_t;

	typedef struct packed {
		logic [5:0] float_voltage_code;
		logic [2:0] charge_current_code;
		logic [1:0] input_current_limit;
		logic [2:0] termination_current_code;
		logic [1:0] weak_battery_threshold;
		logic termination_enable;
		logic charge_disable;
		logic high_impedance_request;
	} chg_cfg_t;

	typedef struct packed {
		logic vbat_below_short;
		logic vbat_at_float;
		logic vbat_below_recharge;
		logic vbat_below_weak;
		logic ichg_below_term;
		logic tj_hot;
		logic vbus_at_special;
		logic vbus_por_ok;
		logic battery_present;
	} chg_flags_t;

	typedef struct packed {
		logic charge_conv_en;
		logic boost_conv_en;
		logic precharge_en;
		logic block_fets;
		logic cv_loop_en;
	} conv_ctrl_t;

endpackage

// ===== hdl/charge_field_regs.sv
// Holds the host-written register images and decodes the charging fields.
// Assumes write strobes come from an I2C slave on the same clock.
`timescale 1ns/10ps
module charge_field_regs
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic ctrl1_we_i,
	input wire logic reg2_we_i,
	input wire logic reg4_we_i,
	input wire logic [7:0] wdata_i,
	output charge_ctrl_pkg::chg_cfg_t cfg_o,
	output logic restart_o,
	output logic [7:0] ctrl1_o
);
	import charge_ctrl_pkg::*;

	logic [7:0] ctrl1;
	logic [7:0] reg2;
	logic [7:0] reg4;

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			ctrl1 <= CTRL1_RESET;
			reg2 <= REG2_RESET;
			reg4 <= REG4_RESET;
		end
		else if (clk_en_i)
		begin
			if (ctrl1_we_i)
				ctrl1 <= wdata_i;
			if (reg2_we_i)
				reg2 <= wdata_i;
			if (reg4_we_i)
				reg4 <= wdata_i;
		end
	end

	// Restart pulse when a write clears charge disable or high impedance
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			restart_o <= 1'b0;
		else if (clk_en_i)
			restart_o <= ctrl1_we_i && ((ctrl1[CTRL1_CD_BIT] && !wdata_i[CTRL1_CD_BIT])
				|| (ctrl1[CTRL1_HZ_BIT] && !wdata_i[CTRL1_HZ_BIT]));
	end

	always_comb
	begin
		cfg_o.float_voltage_code = reg2[REG2_FLOAT_LSB +: 6];
		cfg_o.charge_current_code = reg4[REG4_ICHG_LSB +: 3];
		cfg_o.input_current_limit = ctrl1[CTRL1_INPUT_CURRENT_LIMIT_LSB +: 2];
		cfg_o.termination_current_code = reg4[REG4_TERMINATION_CURRENT_CODE_LSB +: 3];
		cfg_o.weak_battery_threshold = ctrl1[CTRL1_WEAK_LSB +: 2];
		cfg_o.termination_enable = ctrl1[CTRL1_TE_BIT];
		cfg_o.charge_disable = ctrl1[CTRL1_CD_BIT];
		cfg_o.high_impedance_request = ctrl1[CTRL1_HZ_BIT];
	end

	assign ctrl1_o = ctrl1;
endmodule

// ===== hdl/current_ramp.sv
// Slew-limited charge current request toward a target, with thermal backoff.
// Assumes the target and hold flags come from the same clock domain.
`timescale 1ns/10ps
module current_ramp
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic run_i,
	input wire logic backoff_i,
	input wire logic [11:0] target_i,
	output logic [11:0] level_o
);
	import charge_ctrl_pkg::*;

	logic [4:0] tick;
	logic step;

	assign step = (tick == 5'(RAMP_STEP_CYCLES - 1));

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			tick <= '0;
		else if (clk_en_i)
			tick <= (!run_i || step) ? 5'h00 : tick + 5'h01;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			level_o <= '0;
		else if (clk_en_i)
		begin
			if (!run_i)
				level_o <= '0;
			else if (level_o > target_i)
				level_o <= target_i;
			else if (step && backoff_i && level_o != 12'h000)
				level_o <= level_o - 12'h001;
			else if (step && !backoff_i && level_o < target_i)
				level_o <= level_o + 12'h001;
		end
	end
endmodule

// ===== hdl/battery_charge_mode_control.sv
// Top of the charge mode control: mode select, phase sequencer, current request.
// Assumes comparator flags come from analog loops and pass a two-flop synchroniser.
`timescale 1ns/10ps
module battery_charge_mode_control
#(
	parameter int unsigned READY_HOLD = charge_ctrl_pkg::READY_HOLD_CYCLES
)
(
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic clk_en_i,
	input wire logic ctrl1_we_i,
	input wire logic reg2_we_i,
	input wire logic reg4_we_i,
	input wire logic [7:0] wdata_i,
	input wire logic boost_request_i,
	input wire charge_ctrl_pkg::chg_flags_t flags_i,
	output charge_ctrl_pkg::op_mode_t mode_o,
	output charge_ctrl_pkg::chg_state_t state_o,
	output charge_ctrl_pkg::conv_ctrl_t conv_o,
	output logic [1:0] status_o,
	output logic [11:0] input_limit_ma_o,
	output logic [12:0] float_target_mv_o,
	output logic [2:0] term_current_code_o,
	output logic [2:0] charge_current_code_o,
	output logic [11:0] charge_request_o,
	output logic special_limit_o,
	output logic [7:0] ctrl1_o
);
	import charge_ctrl_pkg::*;

	// ==========================================================
	// Decode helpers
	function automatic logic [11:0] input_current_limit_ma(input logic [1:0] code);
		unique case (code)
			2'h0: input_current_limit_ma = INPUT_CURRENT_LIMIT_100_MA;
			2'h1: input_current_limit_ma = INPUT_CURRENT_LIMIT_500_MA;
			2'h2: input_current_limit_ma = INPUT_CURRENT_LIMIT_800_MA;
			2'h3: input_current_limit_ma = INPUT_CURRENT_LIMIT_NONE_MA;
		endcase
	endfunction

	function automatic logic [12:0] float_mv(input logic [5:0] code);
		logic [5:0] sat;
		sat = (code > FLOAT_MAX_CODE) ? FLOAT_MAX_CODE : code;
		float_mv = 13'(FLOAT_BASE_MV) + 13'(sat) * 13'(FLOAT_STEP_MV);
	endfunction

	function automatic logic [11:0] min12(input logic [11:0] a, input logic [11:0] b);
		min12 = (a < b) ? a : b;
	endfunction

	// ==========================================================
	// Input synchronisers
	chg_flags_t flags_meta;
	chg_flags_t flags;
	logic boost_meta;
	logic boost_req;

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			flags_meta <= '0;
			flags <= '0;
			boost_meta <= 1'b0;
			boost_req <= 1'b0;
		end
		else if (clk_en_i)
		begin
			flags_meta <= flags_i;
			flags <= flags_meta;
			boost_meta <= boost_request_i;
			boost_req <= boost_meta;
		end
	end

	// ==========================================================
	// Register fields
	chg_cfg_t cfg;
	logic restart;

	charge_field_regs u_regs
	(
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.ctrl1_we_i(ctrl1_we_i),
		.reg2_we_i(reg2_we_i),
		.reg4_we_i(reg4_we_i),
		.wdata_i(wdata_i),
		.cfg_o(cfg),
		.restart_o(restart),
		.ctrl1_o(ctrl1_o)
	);

	// ==========================================================
	// Mode select
	op_mode_t next_mode;

	always_comb
	begin
		if (cfg.high_impedance_request)
			next_mode = MODE_HIZ;
		else if (boost_req)
			next_mode = MODE_BOOST;
		else if (cfg.charge_disable)
			next_mode = MODE_HIZ;
		else
			next_mode = MODE_CHARGE;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			mode_o <= MODE_HIZ;
		else if (clk_en_i)
			mode_o <= next_mode;
	end

	// ==========================================================
	// Bus reset edge for weak-battery start
	logic por_ok_d;
	logic por_clear;

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			por_ok_d <= 1'b0;
		else if (clk_en_i)
			por_ok_d <= flags.vbus_por_ok;
	end

	assign por_clear = flags.vbus_por_ok && !por_ok_d;

	// ==========================================================
	// Phase sequencer
	chg_state_t state;
	chg_state_t next_state;
	logic new_cycle;
	logic [23:0] hold_cnt;
	logic hold_done;

	assign new_cycle = restart
		|| (por_clear && flags.vbat_below_weak)
		|| flags.vbat_below_recharge;
	assign hold_done = (hold_cnt == 24'(READY_HOLD - 1));

	always_comb
	begin
		next_state = state;
		if (mode_o != MODE_CHARGE)
			next_state = ST_IDLE;
		else
		begin
			unique case (state)
				ST_IDLE, ST_DONE:
					if (new_cycle || state == ST_IDLE && flags.vbus_por_ok)
						next_state = flags.vbat_below_short ? ST_PRE : ST_CC;
				ST_PRE:
					if (!flags.vbat_below_short)
						next_state = ST_CC;
				ST_CC:
					if (flags.vbat_at_float)
						next_state = ST_CV;
				ST_CV:
					if (cfg.termination_enable && flags.ichg_below_term)
						next_state = ST_TERM;
				ST_TERM:
					if (hold_done)
						next_state = (flags.battery_present && flags.vbus_por_ok) ? ST_DONE : ST_IDLE;
				default:
					next_state = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			state <= ST_IDLE;
		else if (clk_en_i)
			state <= next_state;
	end

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			hold_cnt <= '0;
		else if (clk_en_i)
			hold_cnt <= (state == ST_TERM && !hold_done) ? hold_cnt + 24'h00_0001 : 24'h00_0000;
	end

	assign state_o = state;

	// ==========================================================
	// Status and converter controls
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			status_o <= STAT_READY;
			conv_o <= '{charge_conv_en: 1'b0, boost_conv_en: 1'b0, precharge_en: 1'b0,
				block_fets: 1'b1, cv_loop_en: 1'b0};
		end
		else if (clk_en_i)
		begin
			unique case (next_state)
				ST_PRE, ST_CC, ST_CV: status_o <= STAT_CHARGING;
				ST_DONE: status_o <= STAT_DONE;
				default: status_o <= STAT_READY;
			endcase
			conv_o.block_fets <= (next_mode == MODE_HIZ);
			conv_o.boost_conv_en <= (next_mode == MODE_BOOST);
			conv_o.charge_conv_en <= (next_mode == MODE_CHARGE)
				&& (next_state == ST_CC || next_state == ST_CV);
			conv_o.precharge_en <= (next_mode == MODE_CHARGE) && (next_state == ST_PRE);
			conv_o.cv_loop_en <= (next_mode == MODE_CHARGE) && (next_state == ST_CV);
		end
	end

	// ==========================================================
	// Programmed values
	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
		begin
			input_limit_ma_o <= INPUT_CURRENT_LIMIT_100_MA;
			float_target_mv_o <= 13'(FLOAT_BASE_MV);
			term_current_code_o <= '0;
			charge_current_code_o <= '0;
		end
		else if (clk_en_i)
		begin
			input_limit_ma_o <= input_current_limit_ma(cfg.input_current_limit);
			float_target_mv_o <= float_mv(cfg.float_voltage_code);
			term_current_code_o <= cfg.termination_current_code;
			charge_current_code_o <= cfg.charge_current_code;
		end
	end

	// ==========================================================
	// Charge current request: target in charge-code steps of 100 mA scaled
	logic [11:0] chg_target;
	logic ramp_run;
	logic backoff;

	assign chg_target = min12(12'(100) * 12'({1'b0, cfg.charge_current_code} + 4'h1) + 12'h1c2,
		input_current_limit_ma(cfg.input_current_limit));
	assign ramp_run = (mode_o == MODE_CHARGE) && (state == ST_CC || state == ST_CV);
	assign backoff = flags.tj_hot || flags.vbus_at_special;

	current_ramp u_ramp
	(
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.clk_en_i(clk_en_i),
		.run_i(ramp_run),
		.backoff_i(backoff),
		.target_i(chg_target),
		.level_o(charge_request_o)
	);

	always_ff @(posedge core_clk_i or negedge nrst_i)
	begin
		if (!nrst_i)
			special_limit_o <= 1'b0;
		else if (clk_en_i)
			special_limit_o <= ramp_run && flags.vbus_at_special;
	end

	// ==========================================================
	// Checks
	property p_hiz_blocks;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(mode_o == MODE_HIZ) |-> (conv_o.block_fets && !conv_o.boost_conv_en
			&& !conv_o.charge_conv_en && !conv_o.precharge_en);
	endproperty
	a_hiz_blocks: assert property (p_hiz_blocks) else $error("boost on in hiz");

	property p_boost_no_charge;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(mode_o == MODE_BOOST) |-> (state == ST_IDLE || $past(mode_o) != MODE_BOOST || !$past(clk_en_i));
	endproperty
	a_boost_no_charge: assert property (p_boost_no_charge) else $error("charging in boost");

	property p_hiz_priority;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(clk_en_i && cfg.high_impedance_request) |=> (mode_o == MODE_HIZ);
	endproperty
	a_hiz_priority: assert property (p_hiz_priority) else $error("hiz not taken");

	property p_float_sat;
		@(posedge core_clk_i) disable iff (!nrst_i)
		float_target_mv_o <= 13'h1158;
	endproperty
	a_float_sat: assert property (p_float_sat) else $error("float above max");

	property p_cc_bound;
		@(posedge core_clk_i) disable iff (!nrst_i)
		charge_request_o <= input_current_limit_ma(cfg.input_current_limit) || $changed(cfg);
	endproperty
	a_cc_bound: assert property (p_cc_bound) else $error("request over limit");

	property p_term_gate;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(state == ST_CV && !cfg.termination_enable && mode_o == MODE_CHARGE) |=> (state != ST_TERM);
	endproperty
	a_term_gate: assert property (p_term_gate) else $error("terminated with te clear");

	property p_term_ready;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(state == ST_TERM) |-> ##1 (status_o == STAT_READY || state != ST_TERM);
	endproperty
	a_term_ready: assert property (p_term_ready) else $error("not ready in term");

	property p_ramp_slew;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(ramp_run && $past(ramp_run)) |-> (charge_request_o <= $past(charge_request_o) + 12'h001);
	endproperty
	a_ramp_slew: assert property (p_ramp_slew) else $error("ramp too fast");

	property p_pre_state;
		@(posedge core_clk_i) disable iff (!nrst_i)
		(state == ST_PRE && clk_en_i && flags.vbat_below_short && mode_o == MODE_CHARGE) |=> (state == ST_PRE);
	endproperty
	a_pre_state: assert property (p_pre_state) else $error("left precharge early");
endmodule

// ===== tb/charge_loop_model.sv
// Behavioural analog side: turns battery and bus conditions into comparator flags.
// Assumes the bench sets battery voltage and bus conditions as plain levels.
`timescale 1ns/10ps
module charge_loop_model
#(
	parameter logic [12:0] SHORT_MV = 13'h0af0,
	parameter logic [12:0] WEAK_MV = 13'h0d48,
	parameter logic [12:0] RECHARGE_MV = 13'h0064
)
(
	input wire logic [12:0] vbat_mv_i,
	input wire logic [12:0] float_mv_i,
	input wire logic present_i,
	input wire logic por_ok_i,
	input wire logic hot_i,
	input wire logic special_i,
	input wire logic below_term_i,
	output charge_ctrl_pkg::chg_flags_t flags_o
);
	import charge_ctrl_pkg::*;

	// ==========================================================
	// Comparators
	always_comb
	begin
		flags_o.vbat_below_short = vbat_mv_i < SHORT_MV;
		flags_o.vbat_at_float = vbat_mv_i >= float_mv_i;
		flags_o.vbat_below_recharge = vbat_mv_i < (float_mv_i - RECHARGE_MV);
		flags_o.vbat_below_weak = vbat_mv_i < WEAK_MV;
		flags_o.ichg_below_term = below_term_i;
		flags_o.tj_hot = hot_i;
		flags_o.vbus_at_special = special_i;
		flags_o.vbus_por_ok = por_ok_i;
		flags_o.battery_present = present_i;
	end
endmodule

// ===== tb/battery_charge_mode_control_tb.sv
// Bench for the charge mode control: field writes, mode changes, charge phases.
// Assumes the analog side is the behavioural comparator model.
`timescale 1ns/10ps
module battery_charge_mode_control_tb;
	import charge_ctrl_pkg::*;
	logic core_clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic ctrl1_we_i = 1'b0;
	logic reg2_we_i = 1'b0;
	logic reg4_we_i = 1'b0;
	logic [7:0] wdata_i = 8'h00;
	logic boost_request_i = 1'b0;
	logic [12:0] vbat = 13'h09c4;
	logic hot = 1'b0;
	logic special = 1'b0;
	logic below_term = 1'b0;
	logic por_ok = 1'b1;
	logic clk_en = 1'b1;
	logic [7:0] ctrl1_o;
	chg_flags_t flags;
	op_mode_t mode_o;
	chg_state_t state_o;
	conv_ctrl_t conv_o;
	logic [1:0] status_o;
	logic [11:0] input_limit_ma_o;
	logic [12:0] float_target_mv_o;
	logic [2:0] term_current_code_o;
	logic [2:0] charge_current_code_o;
	logic [11:0] charge_request_o;
	logic special_limit_o;
	int failures = 0;
	int n_checks = 0;
	int cycles = 0;
	logic [11:0] lim_tab [4] = '{INPUT_CURRENT_LIMIT_100_MA, INPUT_CURRENT_LIMIT_500_MA, INPUT_CURRENT_LIMIT_800_MA, INPUT_CURRENT_LIMIT_NONE_MA};
	int codes [6] = '{0, 1, 46, 47, 48, 63};
	logic [11:0] held;

	battery_charge_mode_control #(.READY_HOLD(20)) u_battery_charge_mode_control (
		.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en), .ctrl1_we_i(ctrl1_we_i),
		.reg2_we_i(reg2_we_i), .reg4_we_i(reg4_we_i), .wdata_i(wdata_i),
		.boost_request_i(boost_request_i), .flags_i(flags), .mode_o(mode_o), .state_o(state_o),
		.conv_o(conv_o), .status_o(status_o), .input_limit_ma_o(input_limit_ma_o),
		.float_target_mv_o(float_target_mv_o), .term_current_code_o(term_current_code_o),
		.charge_current_code_o(charge_current_code_o), .charge_request_o(charge_request_o),
		.special_limit_o(special_limit_o), .ctrl1_o(ctrl1_o)
	);

	charge_loop_model #(.WEAK_MV(13'h0d7a)) u_charge_loop_model (
		.vbat_mv_i(vbat), .float_mv_i(float_target_mv_o), .present_i(1'b1), .por_ok_i(por_ok),
		.hot_i(hot), .special_i(special), .below_term_i(below_term), .flags_o(flags)
	);

	// ==========================================================
	// Clock and hang guard
	initial
	begin
		forever #25 core_clk_i = ~core_clk_i;
	end

	always @(posedge core_clk_i)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			failures++;
			report_and_stop();
		end
	end

	// ==========================================================
	// Shared tasks
	task automatic check(input string what, input logic [12:0] seen, input logic [12:0] expv);
		n_checks++;
		if (seen !== expv)
		begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, expv, seen);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk_i);
		#1;
	endtask

	// Select 0 first control register, 1 float register, 2 current register
	task automatic wr(input int sel, input logic [7:0] d);
		@(posedge core_clk_i);
		ctrl1_we_i <= (sel == 0);
		reg2_we_i <= (sel == 1);
		reg4_we_i <= (sel == 2);
		wdata_i <= d;
		@(posedge core_clk_i);
		ctrl1_we_i <= 1'b0;
		reg2_we_i <= 1'b0;
		reg4_we_i <= 1'b0;
		tick(3);
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ==========================================================
	// Main sequence
	initial
	begin
		tick(1);
		check("reset mode", 13'(mode_o), 13'(MODE_HIZ));
		check("reset conv", 13'(conv_o), 13'h0002);
		check("reset state", 13'(state_o), 13'(ST_IDLE));
		check("reset limit", 13'(input_limit_ma_o), 13'(INPUT_CURRENT_LIMIT_100_MA));
		check("reset float", float_target_mv_o, 13'h0dac);
		@(posedge core_clk_i);
		nrst_i <= 1'b1;
		wr(0, 8'h02);
		tick(3);
		check("hiz mode", 13'(mode_o), 13'(MODE_HIZ));
		check("hiz conv", 13'(conv_o), 13'h0002);
		@(posedge core_clk_i);
		boost_request_i <= 1'b1;
		tick(6);
		check("hiz over boost", 13'(mode_o), 13'(MODE_HIZ));
		for (int i = 0; i < 4; i++)
		begin
			wr(0, {2'(i), 6'h02});
			check("input limit", 13'(input_limit_ma_o), 13'(lim_tab[i]));
		end
		foreach (codes[i])
		begin
			wr(1, {6'(codes[i]), 2'h0});
			check("float", float_target_mv_o, 13'((codes[i] > 47) ? 4440 : 3500 + 20 * codes[i]));
		end
		wr(2, 8'h57);
		check("charge code", 13'(charge_current_code_o), 13'h0005);
		check("term code", 13'(term_current_code_o), 13'h0007);
		wr(2, 8'h00);
		wr(1, 8'h8c);
		wr(0, 8'h00);
		tick(3);
		check("boost mode", 13'(mode_o), 13'(MODE_BOOST));
		check("boost conv", 13'({conv_o.boost_conv_en, conv_o.charge_conv_en}), 13'h0002);
		@(posedge core_clk_i);
		boost_request_i <= 1'b0;
		tick(6);
		check("charge mode", 13'(mode_o), 13'(MODE_CHARGE));
		check("precharge", 13'(state_o), 13'(ST_PRE));
		check("precharge en", 13'(conv_o.precharge_en), 13'h0001);
		check("charging status", 13'(status_o), 13'(STAT_CHARGING));
		@(posedge core_clk_i);
		vbat <= 13'h0e10;
		tick(160);
		check("cc state", 13'(state_o), 13'(ST_CC));
		check("slew", 13'(charge_request_o > 0 && charge_request_o <= 12), 13'h0001);
		tick(2000);
		check("limited request", 13'(charge_request_o), 13'(INPUT_CURRENT_LIMIT_100_MA));
		@(posedge core_clk_i);
		special <= 1'b1;
		tick(8);
		check("special", 13'(special_limit_o), 13'h0001);
		held = charge_request_o;
		@(posedge core_clk_i);
		special <= 1'b0;
		hot <= 1'b1;
		tick(200);
		check("thermal", 13'(charge_request_o < held), 13'h0001);
		@(posedge core_clk_i);
		hot <= 1'b0;
		vbat <= 13'h1068;
		tick(6);
		check("cv state", 13'(state_o), 13'(ST_CV));
		check("cv loop", 13'(conv_o.cv_loop_en), 13'h0001);
		@(posedge core_clk_i);
		below_term <= 1'b1;
		tick(10);
		check("no term", 13'(state_o), 13'(ST_CV));
		wr(0, 8'h08);
		check("ctrl1 image", 13'(ctrl1_o), 13'h0008);
		check("term state", 13'(state_o), 13'(ST_TERM));
		check("ready status", 13'(status_o), 13'(STAT_READY));
		check("term conv", 13'(conv_o.charge_conv_en), 13'h0000);
		tick(30);
		check("done state", 13'(state_o), 13'(ST_DONE));
		check("done status", 13'(status_o), 13'(STAT_DONE));
		@(posedge core_clk_i);
		below_term <= 1'b0;
		vbat <= 13'h0fa0;
		tick(8);
		check("recharge", 13'(status_o), 13'(STAT_CHARGING));
		// Bus supply not valid: weak battery waits for the bus reset to clear
		@(posedge core_clk_i);
		por_ok <= 1'b0;
		vbat <= 13'h0d5c;
		wr(1, 8'h00);
		wr(0, 8'h0a);
		wr(0, 8'h08);
		check("no bus idle", 13'(state_o), 13'(ST_IDLE));
		@(posedge core_clk_i);
		por_ok <= 1'b1;
		tick(6);
		check("bus reset start", 13'(state_o), 13'(ST_CC));
		// Clock enable low freezes the ramp and the sequencer
		@(posedge core_clk_i);
		clk_en <= 1'b0;
		tick(1);
		held = charge_request_o;
		tick(40);
		check("frozen request", 13'(charge_request_o), 13'(held));
		check("frozen state", 13'(state_o), 13'(ST_CC));
		@(posedge core_clk_i);
		clk_en <= 1'b1;
		tick(2);
		report_and_stop();
	end
endmodule
